// ==== logic/ips_sequencer.sv ====
// Idle power sequencer: APB registers, idle entry and wake exit
//
// Function
// - Idle instruction copies config into status
// - Memory port stays awake while DMA active
// - Writing ones clears interrupt flags
// - Enabled wake runs handler, then resumes
// - Hardware reset ends idle, loses state
// - Light idle keeps clock generator running
// - Deep idle with every domain bit set keeps only RTC clock
// - RTC reboots after RTC-only wake
// - Wake on pin, RTC, INTx, peripherals
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "ips_consts.svh"
module ips_sequencer (
  input wire logic clock_i,                 // 250 MHz system clock
  input wire logic reset_i,                 // Hardware reset, async high
  input wire logic psel_i,                  // APB select
  input wire logic penable_i,               // APB enable
  input wire logic pwrite_i,                // APB direction
  input wire logic [11:0] paddr_i,          // APB byte address
  input wire logic [31:0] pwdata_i,         // APB write data
  output logic [31:0] prdata_o,             // APB read data
  output logic pready_o,                    // APB ready
  output logic pslverr_o,                   // APB error
  input wire logic [15:0] irq_a_i,          // Peripheral events, group a
  input wire logic [15:0] irq_b_i,          // Peripheral events, group b
  input wire logic wake_pin_i,              // Wake pin level
  input wire logic rtc_irq_i,               // RTC interrupt
  input wire logic rtc_only_i,              // Chip was in RTC-only mode
  input wire logic isr_done_i,              // CPU returned from handler
  output ips_pkg::ips_clk_en_type clk_en_o, // Domain clock enables
  output logic memory_port_idle_o,                // Memory port idled
  output logic isr_req_o,                   // Dispatch wake handler
  output logic idle_o,                      // Idle in force
  output logic rtc_reboot_o                 // RTC reboot pulse
);
  ips_pkg::ips_state_type state_ff;
  ips_pkg::ips_state_type nxt_state;
  logic [10:0] cfg_ff;
  logic [10:0] nxt_cfg;
  logic [10:0] stat_ff;
  logic [10:0] nxt_stat;
  logic [15:0] en_a_ff;
  logic [15:0] nxt_en_a;
  logic [15:0] en_b_ff;
  logic [15:0] nxt_en_b;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic ready_ff;
  logic nxt_ready;
  logic err_ff;
  logic nxt_err;
  logic isr_ff;
  logic nxt_isr;
  logic idle_ff;
  logic nxt_idle;
  logic reboot_ff;
  logic nxt_reboot;
  logic deep_ff;
  logic nxt_deep;
  logic [15:0] flag_a;
  logic [15:0] flag_b;
  logic [15:0] set_b;
  logic wr_a;
  logic wr_b;
  logic access;
  logic wake;

  // Byte address matches a register offset
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr == off);
  endfunction

  // Two-cycle access phase: ready follows the first enable cycle
  assign access = psel_i && penable_i && !ready_ff;
  assign wr_a = access && pwrite_i && hit(paddr_i, `IPS_OFF_IRQ_FLAG_A);
  assign wr_b = access && pwrite_i && hit(paddr_i, `IPS_OFF_IRQ_FLAG_B);
  // RTC and wake pin share one flag bit
  assign set_b = irq_b_i | ({15'h0000, rtc_irq_i || wake_pin_i} << `IPS_FLAG_RTC);

  ips_flag_bank u_flag_a (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .set_i(irq_a_i),
    .clr_we_i(wr_a),
    .clr_data_i(pwdata_i[15:0]),
    .flag_o(flag_a)
  );

  ips_flag_bank u_flag_b (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .set_i(set_b),
    .clr_we_i(wr_b),
    .clr_data_i(pwdata_i[15:0]),
    .flag_o(flag_b)
  );

  ips_gate_ctrl u_gate (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .state_i(stat_ff),
    .active_i(idle_ff),
    .clk_en_o(clk_en_o),
    .memory_port_idle_o(memory_port_idle_o)
  );

  // Any enabled pending flag wakes the device; INT0/INT1 live in group a
  assign wake = |(flag_a & en_a_ff) || |(flag_b & en_b_ff);

  // Register file: writes, reads and slave answer
  always_comb
  begin
    nxt_cfg = cfg_ff;
    nxt_en_a = en_a_ff;
    nxt_en_b = en_b_ff;
    nxt_rdata = rdata_ff;
    nxt_ready = 1'b0;
    nxt_err = 1'b0;
    if (access)
    begin
      nxt_ready = 1'b1;
      nxt_rdata = 32'h0000_0000;
      case (paddr_i)
        `IPS_OFF_IDLE_CFG:
        begin
          if (pwrite_i)
          begin
            nxt_cfg = pwdata_i[10:0];
          end
          nxt_rdata = {21'h00_0000, cfg_ff};
        end
        `IPS_OFF_IDLE_STATE:
        begin
          nxt_rdata = {21'h00_0000, stat_ff};
        end
        `IPS_OFF_IRQ_FLAG_A:
        begin
          nxt_rdata = {16'h0000, flag_a};
        end
        `IPS_OFF_IRQ_FLAG_B:
        begin
          nxt_rdata = {16'h0000, flag_b};
        end
        `IPS_OFF_IRQ_EN_A:
        begin
          if (pwrite_i)
          begin
            nxt_en_a = pwdata_i[15:0];
          end
          nxt_rdata = {16'h0000, en_a_ff};
        end
        `IPS_OFF_IRQ_EN_B:
        begin
          if (pwrite_i)
          begin
            nxt_en_b = pwdata_i[15:0];
          end
          nxt_rdata = {16'h0000, en_b_ff};
        end
        `IPS_OFF_IDLE_CMD:
        begin
          nxt_rdata = 32'h0000_0000;
        end
        `IPS_OFF_STATUS:
        begin
          nxt_rdata = {27'h000_0000, deep_ff, isr_ff, idle_ff, 2'b00};
        end
        default:
        begin
          nxt_err = 1'b1; // Unmapped address
        end
      endcase
    end
  end

  // Idle sequencer: enter, hold, wake, handler
  always_comb
  begin
    nxt_state = state_ff;
    nxt_stat = stat_ff;
    nxt_cnt = cnt_ff;
    nxt_isr = 1'b0;
    nxt_idle = idle_ff;
    nxt_reboot = 1'b0;
    nxt_deep = deep_ff;
    case (state_ff)
      ips_pkg::IPS_RUN:
      begin
        // One command is one instruction, so no pairing can occur
        if (access && pwrite_i && hit(paddr_i, `IPS_OFF_IDLE_CMD) &&
            pwdata_i == `IPS_IDLE_KEY)
        begin
          nxt_stat = cfg_ff;
          nxt_deep = cfg_ff[`IPS_BIT_CLKGEN];
          nxt_cnt = `IPS_PROP_CYC;
          nxt_state = ips_pkg::IPS_ENTER;
        end
      end
      ips_pkg::IPS_ENTER:
      begin
        // Status bits ripple through the CPU domain before gating
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h1)
        begin
          nxt_idle = 1'b1;
          nxt_state = ips_pkg::IPS_IDLE;
        end
      end
      ips_pkg::IPS_IDLE:
      begin
        if (wake)
        begin
          nxt_idle = 1'b0;
          nxt_stat = 11'h000;
          nxt_reboot = rtc_only_i;
          nxt_state = ips_pkg::IPS_WAKE;
        end
      end
      ips_pkg::IPS_WAKE:
      begin
        // Gate stage has one cycle to reopen CPU clock before dispatch
        nxt_isr = 1'b1;
        nxt_state = ips_pkg::IPS_ISR;
      end
      ips_pkg::IPS_ISR:
      begin
        nxt_isr = !isr_done_i;
        if (isr_done_i)
        begin
          nxt_deep = 1'b0; // Resume after idle point
          nxt_state = ips_pkg::IPS_RUN;
        end
      end
      default:
      begin
        nxt_state = ips_pkg::IPS_RUN;
      end
    endcase
  end

  // All state clears on hardware reset, pre-idle state lost
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_ff <= ips_pkg::IPS_RUN;
      cfg_ff <= `IPS_CFG_RST;
      stat_ff <= `IPS_CFG_RST;
      en_a_ff <= `IPS_FLAG_RST;
      en_b_ff <= `IPS_FLAG_RST;
      cnt_ff <= 4'h0;
      rdata_ff <= 32'h0000_0000;
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
      isr_ff <= 1'b0;
      idle_ff <= 1'b0;
      reboot_ff <= 1'b0;
      deep_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cfg_ff <= nxt_cfg;
      stat_ff <= nxt_stat;
      en_a_ff <= nxt_en_a;
      en_b_ff <= nxt_en_b;
      cnt_ff <= nxt_cnt;
      rdata_ff <= nxt_rdata;
      ready_ff <= nxt_ready;
      err_ff <= nxt_err;
      isr_ff <= nxt_isr;
      idle_ff <= nxt_idle;
      reboot_ff <= nxt_reboot;
      deep_ff <= nxt_deep;
    end
  end

  // Outputs straight from flip-flops
  assign prdata_o = rdata_ff;
  assign pready_o = ready_ff;
  assign pslverr_o = err_ff;
  assign isr_req_o = isr_ff;
  assign idle_o = idle_ff;
  assign rtc_reboot_o = reboot_ff;
endmodule // ips_sequencer

// ==== logic/ips_consts.svh ====
// Constants of the idle power sequencer: offsets, fields, resets, timing
`ifndef IPS_CONSTS_SVH
`define IPS_CONSTS_SVH
// Register byte offsets on APB
`define IPS_OFF_IDLE_CFG   12'h000
`define IPS_OFF_IDLE_STATE 12'h004
`define IPS_OFF_IRQ_FLAG_A 12'h008
`define IPS_OFF_IRQ_FLAG_B 12'h00C
`define IPS_OFF_IRQ_EN_A   12'h010
`define IPS_OFF_IRQ_EN_B   12'h014
`define IPS_OFF_IDLE_CMD   12'h018
`define IPS_OFF_STATUS     12'h01C
// Idle configuration field positions
`define IPS_BIT_CORE   0
`define IPS_BIT_MEMORY_PORT  1
`define IPS_BIT_XPORT  2
`define IPS_BIT_DPORT  3
`define IPS_BIT_IPORT  4
`define IPS_BIT_CLKP   5
`define IPS_BIT_PERIPH 6
`define IPS_BIT_USB    7
`define IPS_BIT_CLKGEN 8
`define IPS_BIT_DMA    9
`define IPS_BIT_USB_COMM_DMA   10
`define IPS_CFG_W      11
// Flag bits that name wake sources in irq_flag_reg_a
`define IPS_FLAG_INT0  2
`define IPS_FLAG_INT1  3
// Flag bit in irq_flag_reg_b for the RTC / wake pin
`define IPS_FLAG_RTC   2
// Reset values
`define IPS_CFG_RST    11'h000
`define IPS_FLAG_RST   16'h0000
// Command word that models the idle instruction
`define IPS_IDLE_KEY   32'h0000_1D1E
// Cycles the clock path takes to propagate state
`define IPS_PROP_CYC   4'h2
`endif

// ==== logic/ips_pkg.sv ====
// Types of the idle power sequencer
package ips_pkg;
  typedef enum logic [2:0] {
    IPS_RUN,
    IPS_ENTER,
    IPS_IDLE,
    IPS_WAKE,
    IPS_ISR
  } ips_state_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ips_apb_req_type;
  typedef struct packed {
    logic core;
    logic periph;
    logic usb;
    logic clkgen;
    logic rtc;
  } ips_clk_en_type;
endpackage

// ==== logic/ips_flag_bank.sv ====
// Sticky interrupt flag register with write-one-to-clear
`timescale 1ns/10ps
`include "ips_consts.svh"
module ips_flag_bank (
  input wire logic clock_i,           // System clock
  input wire logic reset_i,           // Async reset, high
  input wire logic [15:0] set_i,      // Hardware events
  input wire logic clr_we_i,          // Write strobe
  input wire logic [15:0] clr_data_i, // Ones clear
  output logic [15:0] flag_o          // Flag state
);
  logic [15:0] flag_ff;
  logic [15:0] nxt_flag;

  // Set wins over a clear in the same cycle
  always_comb
  begin
    nxt_flag = flag_ff;
    if (clr_we_i)
    begin
      nxt_flag = nxt_flag & ~clr_data_i;
    end
    nxt_flag = nxt_flag | set_i;
  end

  // Flag storage
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      flag_ff <= `IPS_FLAG_RST;
    end
    else
    begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag_o = flag_ff;
endmodule // ips_flag_bank

// ==== logic/ips_gate_ctrl.sv ====
// Clock gate computation from the idle status bits
`timescale 1ns/10ps
`include "ips_consts.svh"
module ips_gate_ctrl (
  input wire logic clock_i,                 // System clock
  input wire logic reset_i,                 // Async reset, high
  input wire logic [10:0] state_i,          // Idle status bits
  input wire logic active_i,                // Idle in force
  output ips_pkg::ips_clk_en_type clk_en_o, // Domain clock enables
  output logic memory_port_idle_o                 // Memory port idled
);
  ips_pkg::ips_clk_en_type en_ff;
  ips_pkg::ips_clk_en_type nxt_en;
  logic memory_port_ff;
  logic nxt_memory_port;

  // Status bits only act while idle is in force; RTC never stops
  always_comb
  begin
    nxt_en.rtc = 1'b1;
    nxt_en.core = !(active_i && state_i[`IPS_BIT_CORE] && state_i[`IPS_BIT_CLKP]);
    nxt_en.periph = !(active_i && state_i[`IPS_BIT_PERIPH]);
    nxt_en.usb = !(active_i && state_i[`IPS_BIT_USB]);
    nxt_en.clkgen = !(active_i && state_i[`IPS_BIT_CLKGEN]);
    // Memory port held awake while any DMA still runs
    nxt_memory_port = active_i && state_i[`IPS_BIT_MEMORY_PORT] &&
                state_i[`IPS_BIT_DMA] && state_i[`IPS_BIT_USB_COMM_DMA];
  end

  // Registered so that enables are glitch free
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      en_ff <= 5'b1_1111;
      memory_port_ff <= 1'b0;
    end
    else
    begin
      en_ff <= nxt_en;
      memory_port_ff <= nxt_memory_port;
    end
  end

  assign clk_en_o = en_ff;
  assign memory_port_idle_o = memory_port_ff;
endmodule // ips_gate_ctrl

// ==== test/ips_sequencer_sva.sv ====
// Concurrent checks on the idle power sequencer ports
`timescale 1ns/10ps
module ips_sequencer_sva (
  input wire logic clock_i,                     // System clock
  input wire logic reset_i,                     // Async reset, high
  input wire logic psel_i,                      // APB select
  input wire logic penable_i,                   // APB enable
  input wire logic pready_o,                    // APB ready
  input wire logic pslverr_o,                   // APB error
  input wire logic isr_done_i,                  // Handler returned
  input wire ips_pkg::ips_clk_en_type clk_en_o, // Clock enables
  input wire logic isr_req_o,                   // Handler dispatch
  input wire logic idle_o,                      // Idle in force
  input wire logic rtc_reboot_o                 // RTC reboot pulse
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // Register access always gets exactly one wait state
  a_ready_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("ready late");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  // Dispatch must find every clock reopened
  a_wake_dispatch: assert property ($fell(idle_o) |=> isr_req_o && clk_en_o == 5'h1F)
    else $error("wake dispatch wrong");
  a_isr_clock_on: assert property (isr_req_o |-> clk_en_o.core && !idle_o)
    else $error("handler without core clock");
  a_isr_release: assert property (isr_req_o && isr_done_i |=> !isr_req_o)
    else $error("handler not released");
  a_reboot_on_wake: assert property (rtc_reboot_o |-> $fell(idle_o) ##1 !rtc_reboot_o)
    else $error("reboot pulse wrong");
  a_rtc_alive: assert property (clk_en_o.rtc)
    else $error("rtc clock stopped");
  a_idle_no_isr: assert property ($rose(idle_o) |-> !isr_req_o [*2])
    else $error("dispatch at idle entry");
endmodule // ips_sequencer_sva

// ==== test/test_ips_sequencer.sv ====
// Self-checking bench for the idle power sequencer
`timescale 1ns/10ps
`include "ips_consts.svh"
module test_ips_sequencer;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [15:0] irq_a_i = 16'h0000, irq_b_i = 16'h0000;
  logic wake_pin_i = 1'b0, rtc_irq_i = 1'b0, rtc_only_i = 1'b0, isr_done_i = 1'b0;
  logic [31:0] prdata_o, rd;
  logic pready_o, pslverr_o, memory_port_idle_o, isr_req_o, idle_o, rtc_reboot_o, er;
  ips_pkg::ips_clk_en_type clk_en_o;
  int error_cnt = 0, checked = 0, cyc = 0, reboots = 0;
  // 250 MHz clock
  always #2 clock_i = ~clock_i;
  ips_sequencer uut (.clock_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .irq_a_i, .irq_b_i, .wake_pin_i,
    .rtc_irq_i, .rtc_only_i, .isr_done_i, .clk_en_o, .memory_port_idle_o, .isr_req_o,
    .idle_o, .rtc_reboot_o);
  // Hang guard and reboot pulse counter
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (rtc_reboot_o === 1'b1) reboots <= reboots + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One APB transfer; an idle edge follows so a next call never re-drives psel in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    @(posedge clock_i);
    // No wait count is assumed; only the hang guard ends a stalled access
    while (pready_o !== 1'b1)
    begin
      @(posedge clock_i);
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask
  // Raise one wake source for a single cycle
  task automatic fire(input int s);
    case (s)
      0: irq_a_i <= 16'h0004;
      1: irq_a_i <= 16'h0008;
      2: irq_a_i <= 16'h0020;
      3: wake_pin_i <= 1'b1;
      default: rtc_irq_i <= 1'b1;
    endcase
    @(posedge clock_i);
    irq_a_i <= 16'h0000;
    wake_pin_i <= 1'b0;
    rtc_irq_i <= 1'b0;
  endtask
  // Full entry, wake, handler and return
  task automatic idle_run(input logic [31:0] cfg, input int s, input logic [4:0] ck,
                          input logic mp);
    int rb;
    wr(`IPS_OFF_IDLE_CFG, cfg);
    wr(`IPS_OFF_IRQ_FLAG_A, 32'h0000_FFFF);
    wr(`IPS_OFF_IRQ_FLAG_B, 32'h0000_FFFF);
    rdc(`IPS_OFF_IRQ_FLAG_A, 32'h0000_0000);
    wr(`IPS_OFF_IDLE_CMD, `IPS_IDLE_KEY);
    repeat (5) @(posedge clock_i);
    chk(idle_o, 1'b1);
    chk(clk_en_o, ck);
    chk(memory_port_idle_o, mp);
    rdc(`IPS_OFF_IDLE_STATE, cfg);
    rdc(`IPS_OFF_STATUS, {27'h000_0000, cfg[`IPS_BIT_CLKGEN], 4'h4});
    rb = reboots;
    fire(s);
    while (isr_req_o !== 1'b1)
    begin
      @(posedge clock_i);
    end
    @(posedge clock_i);
    chk(clk_en_o, 5'h1F);
    chk(idle_o, 1'b0);
    chk(reboots - rb, rtc_only_i);
    // A command inside the handler must be ignored
    wr(`IPS_OFF_IDLE_CMD, `IPS_IDLE_KEY);
    repeat (3) @(posedge clock_i);
    chk(idle_o, 1'b0);
    rdc(`IPS_OFF_STATUS, {27'h000_0000, cfg[`IPS_BIT_CLKGEN], 4'h8});
    isr_done_i <= 1'b1;
    @(posedge clock_i);
    isr_done_i <= 1'b0;
    @(posedge clock_i);
    chk(isr_req_o, 1'b0);
  endtask
  initial
  begin
    int k, v;
    v = $urandom(32'ha398);
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    chk(clk_en_o, 5'h1F);
    rdc(`IPS_OFF_IDLE_STATE, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    // Random events, then clear a random subset by ones
    v = $urandom & 32'h0000_FFFF;
    irq_b_i <= v[15:0];
    @(posedge clock_i);
    irq_b_i <= 16'h0000;
    @(posedge clock_i);
    rdc(`IPS_OFF_IRQ_FLAG_B, v);
    k = $urandom & v;
    wr(`IPS_OFF_IRQ_FLAG_B, k);
    rdc(`IPS_OFF_IRQ_FLAG_B, v & ~k);
    wr(`IPS_OFF_IRQ_EN_A, 32'h0000_002C);
    wr(`IPS_OFF_IRQ_EN_B, 32'h0000_0004);
    rdc(`IPS_OFF_IRQ_EN_A, 32'h0000_002C);
    rdc(`IPS_OFF_IRQ_EN_B, 32'h0000_0004);
    // Light then deep idle, each woken by every source
    for (k = 0; k < 5; k++) idle_run(32'h0000_00FF, k, 5'h03, 1'b0);
    rtc_only_i <= 1'b1;
    for (k = 0; k < 5; k++) idle_run(32'h0000_07FF, k, 5'h01, 1'b1);
    rtc_only_i <= 1'b0;
    // Room for the PLL to relock before full-speed work resumes
    repeat (8) @(posedge clock_i);
    // Bench keeps one clock rate and never scales the core supply
    // Hardware reset in deep idle loses all state
    wr(`IPS_OFF_IRQ_FLAG_A, 32'h0000_FFFF);
    wr(`IPS_OFF_IRQ_FLAG_B, 32'h0000_FFFF);
    wr(`IPS_OFF_IDLE_CMD, `IPS_IDLE_KEY);
    repeat (5) @(posedge clock_i);
    chk(idle_o, 1'b1);
    reset_i <= 1'b1;
    @(posedge clock_i);
    chk(idle_o, 1'b0);
    chk(clk_en_o, 5'h1F);
    reset_i <= 1'b0;
    @(posedge clock_i);
    rdc(`IPS_OFF_IDLE_CFG, 32'h0000_0000);
    rdc(`IPS_OFF_IRQ_EN_A, 32'h0000_0000);
    give_verdict();
  end
endmodule // test_ips_sequencer
bind ips_sequencer ips_sequencer_sva sva_u (.clock_i, .reset_i, .psel_i, .penable_i,
  .pready_o, .pslverr_o, .isr_done_i, .clk_en_o, .isr_req_o, .idle_o, .rtc_reboot_o);
